// ==== rtl/seeng_engine.sv ====
// Serial EEPROM command engine: three-wire slave plus self-timed array.
// Assumes each serial clock phase lasts several clk cycles.
`timescale 1ns/1ps

module seeng_engine #(
   parameter int PROG_CYCLES = seeng_pkg::PROG_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Serial pins from the host
   input  wire logic chip_select,
   input  wire logic serial_clock_in,
   input  wire logic serial_in,
   input  wire logic program_enable_pin,
   // Serial output, two signals (oe low = driving)
   output logic      serial_out,
   output logic      serial_out_oe_n,
   // Status
   output logic      busy
);

   // =========================================================
   // Storage and state
   // =========================================================
   logic [seeng_pkg::DATA_W-1:0] mem [seeng_pkg::WORDS];
   seeng_pkg::seeng_pins_s        pin;      // filtered pin levels
   seeng_pkg::seeng_pins_s        pin_d;    // previous levels
   seeng_pkg::seeng_state_e       state;
   seeng_pkg::seeng_job_e         job;
   logic [1:0]                    opcode;
   logic [seeng_pkg::ADDR_W-1:0]  addr;     // command / read address
   logic [seeng_pkg::DATA_W-1:0]  wdata;    // write data shift
   logic [seeng_pkg::DATA_W-1:0]  rword;    // read output shift
   logic [5:0]                    bitcnt;   // bits in current field
   logic                          wel;      // write-enable latch
   logic [seeng_pkg::CNT_W-1:0]   timer;    // self-timed cycle
   logic [seeng_pkg::ADDR_W-1:0]  sweep;    // array-wide address
   logic                          sweep_on; // sweep in progress
   logic                          sk_rise;
   logic                          cs_fall;
   logic                          cs_rise;
   logic                          mod_ok;   // modify allowed
   logic [1:0]                    sub_sel;  // special-group selector
   logic [seeng_pkg::DATA_W-1:0]  rd_word;  // word loaded for output

   // Field lengths: opcode takes 2, address ADDR_W
   localparam logic [5:0] CMD_BITS  = 6'(2 + seeng_pkg::ADDR_W);
   localparam logic [5:0] DATA_BITS = 6'(seeng_pkg::DATA_W);
   localparam logic [seeng_pkg::CNT_W-1:0] TIMER_END =
      seeng_pkg::CNT_W'(PROG_CYCLES - 1);

   // Next-address helper, wraps naturally at the top
   function automatic logic [seeng_pkg::ADDR_W-1:0] next_addr_of(
      input logic [seeng_pkg::ADDR_W-1:0] a);
      next_addr_of = a + seeng_pkg::ADDR_W'(1);
   endfunction : next_addr_of

   // =========================================================
   // Pin synchronisation and edge detection
   // =========================================================
   seeng_sync #(
      .W (4)
   ) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .raw    ({chip_select, serial_clock_in, serial_in,
                program_enable_pin}),
      .level  (pin)
   );

   // Previous filtered levels for edge detection
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_d <= '0;
      end else begin
         pin_d <= pin;
      end
   end

   assign sk_rise = pin.cs && pin.sclk && !pin_d.sclk;
   assign cs_fall = !pin.cs && pin_d.cs;
   assign cs_rise = pin.cs && !pin_d.cs;
   // Modifying commands need both latch and enable pin
   assign mod_ok  = wel && pin.pe;
   // Top two address bits shifted so far, valid on the last bit
   assign sub_sel = addr[seeng_pkg::ADDR_W-2:seeng_pkg::ADDR_W-3];
   assign rd_word = (bitcnt == DATA_BITS) ? mem[next_addr_of(addr)]
                                          : mem[addr];

   // =========================================================
   // Command sequencer
   // =========================================================
   // Deselect aborts any unfinished shift; ARMED launches on fall
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state  <= seeng_pkg::SEENG_IDLE;
         opcode <= 2'h0;
         addr   <= seeng_pkg::ADDR_RST;
         wdata  <= '0;
         bitcnt <= seeng_pkg::CNT_RST;
         job    <= seeng_pkg::SEENG_JOB_WORD;
      end else begin
         unique case (state)
            // Ignore input until a one arrives while selected
            seeng_pkg::SEENG_IDLE: begin
               bitcnt <= seeng_pkg::CNT_RST;
               if (sk_rise && pin.sin) begin
                  state <= seeng_pkg::SEENG_CMD;
               end
            end
            // Opcode then address, MSB first
            seeng_pkg::SEENG_CMD: begin
               if (!pin.cs) begin
                  state <= seeng_pkg::SEENG_IDLE;
               end else if (sk_rise) begin
                  bitcnt <= bitcnt + 6'h01;
                  if (bitcnt < 6'h02) begin
                     opcode <= {opcode[0], pin.sin};
                  end else begin
                     addr <= {addr[seeng_pkg::ADDR_W-2:0], pin.sin};
                  end
                  if (bitcnt == CMD_BITS - 6'h01) begin
                     bitcnt <= seeng_pkg::CNT_RST;
                     unique case (opcode)
                        seeng_pkg::OP_READ: begin
                           // Read works regardless of latch
                           state <= seeng_pkg::SEENG_READ;
                        end
                        seeng_pkg::OP_WRITE: begin
                           job   <= seeng_pkg::SEENG_JOB_WORD;
                           state <= seeng_pkg::SEENG_DATA;
                        end
                        seeng_pkg::OP_ERASE: begin
                           job   <= seeng_pkg::SEENG_JOB_CLEAR;
                           state <= seeng_pkg::SEENG_ARMED;
                        end
                        seeng_pkg::OP_SPECIAL: begin
                           state <= seeng_pkg::SEENG_DONE;
                           if (sub_sel == seeng_pkg::SUB_WRITE_ALL) begin
                              job   <= seeng_pkg::SEENG_JOB_FILL;
                              state <= seeng_pkg::SEENG_DATA;
                           end else if (sub_sel ==
                                        seeng_pkg::SUB_ERASE_ALL) begin
                              job   <= seeng_pkg::SEENG_JOB_WIPE;
                              state <= seeng_pkg::SEENG_ARMED;
                           end
                        end
                     endcase
                  end
               end
            end
            // Write data field
            seeng_pkg::SEENG_DATA: begin
               if (!pin.cs) begin
                  state <= seeng_pkg::SEENG_IDLE;
               end else if (sk_rise) begin
                  wdata  <= {wdata[seeng_pkg::DATA_W-2:0], pin.sin};
                  bitcnt <= bitcnt + 6'h01;
                  if (bitcnt == DATA_BITS - 6'h01) begin
                     state <= seeng_pkg::SEENG_ARMED;
                  end
               end
            end
            // Stream words until deselect
            seeng_pkg::SEENG_READ: begin
               if (!pin.cs) begin
                  state <= seeng_pkg::SEENG_IDLE;
               end else if (sk_rise) begin
                  bitcnt <= bitcnt + 6'h01;
                  if (bitcnt == DATA_BITS) begin
                     bitcnt <= 6'h01;
                     addr   <= next_addr_of(addr);
                  end
               end
            end
            // Launch on deselect if allowed
            seeng_pkg::SEENG_ARMED: begin
               if (cs_fall) begin
                  state <= mod_ok ? seeng_pkg::SEENG_BUSY
                                  : seeng_pkg::SEENG_IDLE;
               end
            end
            // Self-timed cycle, independent of serial clock
            seeng_pkg::SEENG_BUSY: begin
               if (timer == TIMER_END && !sweep_on) begin
                  state <= seeng_pkg::SEENG_DONE;
               end
            end
            // Wait for deselect, or a fresh start after status poll
            seeng_pkg::SEENG_DONE: begin
               if (!pin.cs) begin
                  state <= seeng_pkg::SEENG_IDLE;
               end else if (sk_rise && pin.sin) begin
                  bitcnt <= seeng_pkg::CNT_RST;
                  state  <= seeng_pkg::SEENG_CMD;
               end
            end
            default: begin
               state <= seeng_pkg::SEENG_IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // Write-enable latch
   // =========================================================
   // Special commands act on their last address bit, pin ignored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wel <= 1'b0;
      end else if (state == seeng_pkg::SEENG_CMD && sk_rise &&
                   bitcnt == CMD_BITS - 6'h01 &&
                   opcode == seeng_pkg::OP_SPECIAL) begin
         if (sub_sel == seeng_pkg::SUB_WRITE_ENABLE) begin
            wel <= 1'b1;
         end else if (sub_sel == seeng_pkg::SUB_WRITE_DISABLE) begin
            wel <= 1'b0;
         end
      end
   end

   // =========================================================
   // Self-timed array cycle
   // =========================================================
   // Timer runs the program pulse; sweep walks the whole array
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer    <= '0;
         sweep    <= seeng_pkg::ADDR_RST;
         sweep_on <= 1'b0;
      end else if (state == seeng_pkg::SEENG_ARMED && cs_fall &&
                   mod_ok) begin
         timer    <= '0;
         sweep    <= seeng_pkg::ADDR_RST;
         sweep_on <= (job == seeng_pkg::SEENG_JOB_FILL) ||
                     (job == seeng_pkg::SEENG_JOB_WIPE);
      end else if (state == seeng_pkg::SEENG_BUSY) begin
         if (timer != TIMER_END) begin
            timer <= timer + seeng_pkg::CNT_W'(1);
         end
         if (sweep_on) begin
            sweep <= next_addr_of(sweep);
            if (sweep == '1) begin
               sweep_on <= 1'b0;
            end
         end
      end
   end

   // Array write: words overwrite whole, so no pre-clear needed
   always_ff @(posedge clk) begin
      if (state == seeng_pkg::SEENG_BUSY) begin
         unique case (job)
            seeng_pkg::SEENG_JOB_WORD: begin
               mem[addr] <= wdata;
            end
            seeng_pkg::SEENG_JOB_CLEAR: begin
               mem[addr] <= seeng_pkg::ERASED;
            end
            seeng_pkg::SEENG_JOB_FILL: begin
               if (sweep_on) begin
                  mem[sweep] <= wdata;
               end
            end
            seeng_pkg::SEENG_JOB_WIPE: begin
               if (sweep_on) begin
                  mem[sweep] <= seeng_pkg::ERASED;
               end
            end
         endcase
      end
   end

   // =========================================================
   // Serial output
   // =========================================================
   // Read: dummy zero after address, then MSB-first words
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         serial_out      <= 1'b0;
         serial_out_oe_n <= 1'b1;
         rword           <= '0;
      end else if (state == seeng_pkg::SEENG_CMD && sk_rise &&
                   bitcnt == CMD_BITS - 6'h01 &&
                   opcode == seeng_pkg::OP_READ) begin
         serial_out      <= 1'b0;
         serial_out_oe_n <= 1'b0;
      end else if (state == seeng_pkg::SEENG_READ) begin
         if (!pin.cs) begin
            serial_out_oe_n <= 1'b1;
         end else if (sk_rise) begin
            if (bitcnt == seeng_pkg::CNT_RST || bitcnt == DATA_BITS) begin
               // Load the word: current or next address
               rword      <= {rd_word[seeng_pkg::DATA_W-2:0], 1'b0};
               serial_out <= rd_word[seeng_pkg::DATA_W-1];
            end else begin
               serial_out <= rword[seeng_pkg::DATA_W-1];
               rword      <= {rword[seeng_pkg::DATA_W-2:0], 1'b0};
            end
         end
      end else if (pin.cs && (state == seeng_pkg::SEENG_BUSY ||
                              state == seeng_pkg::SEENG_DONE)) begin
         // Status while selected after a launch or an enable/disable command
         serial_out      <= (state == seeng_pkg::SEENG_DONE);
         serial_out_oe_n <= 1'b0;
      end else begin
         serial_out_oe_n <= 1'b1;
      end
   end

   // Busy flag straight from a flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state == seeng_pkg::SEENG_BUSY);
      end
   end

endmodule : seeng_engine

// ==== rtl/seeng_pkg.sv ====
// Constants and carrier types for the serial EEPROM command engine.
// Assumes a single 100 MHz clock; all pins are sampled as async inputs.
//
// Contract
// - Start bit, opcode, address, then data
// - Input bits taken on serial clock rise
// - Busy low, ready high while selected
// - Modifying commands need program enable high
// - Read sends dummy zero, then MSB first
// - Read output changes on clock rise
// - Held select continues with next word
// - Sequential read wraps address to zero
// - Dummy zero only before first word
// - Select fall launches clear and program
// - Self-timed cycle needs no serial clock
// - Write auto-clears before programming
// - Erase leaves location all ones
// - Write enable latch off at reset
// - Enable command precedes any modification
// - Latch holds until disable or reset
// - Latch off rejects all modifying commands
// - Reads ignore the latch state
// - Erase-all leaves whole array ones
// - Write-all programs word everywhere
// - Write-all needs no prior erase

package seeng_pkg;

   // =========================================================
   // Array geometry
   // =========================================================
   localparam int ADDR_W = 10;             // x16 organisation
   localparam int DATA_W = 16;
   localparam int WORDS  = 1 << ADDR_W;

   // =========================================================
   // Opcodes
   // =========================================================
   localparam logic [1:0] OP_SPECIAL = 2'h0;
   localparam logic [1:0] OP_WRITE   = 2'h1;
   localparam logic [1:0] OP_READ    = 2'h2;
   localparam logic [1:0] OP_ERASE   = 2'h3;
   // Special group selectors (top two address bits)
   localparam logic [1:0] SUB_WRITE_DISABLE = 2'h0;
   localparam logic [1:0] SUB_WRITE_ALL     = 2'h1;
   localparam logic [1:0] SUB_ERASE_ALL     = 2'h2;
   localparam logic [1:0] SUB_WRITE_ENABLE  = 2'h3;

   // =========================================================
   // Timing
   // =========================================================
   localparam int CLK_MHZ        = 100;
   localparam int PROG_TIME_US   = 5000;   // program/erase pulse
   localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
   localparam int CNT_W          = 20;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 10'h000;
   localparam logic [DATA_W-1:0] ERASED    = 16'hFFFF;
   localparam logic [5:0]        CNT_RST   = 6'h00;

   // =========================================================
   // Types
   // =========================================================
   typedef enum logic [2:0] {
      SEENG_IDLE  = 3'b000,   // wait start bit
      SEENG_CMD   = 3'b001,   // opcode + address
      SEENG_DATA  = 3'b011,   // write data
      SEENG_READ  = 3'b010,   // shifting out
      SEENG_ARMED = 3'b110,   // wait deselect
      SEENG_BUSY  = 3'b111,   // self-timed cycle
      SEENG_DONE  = 3'b101    // wait deselect or new start bit
   } seeng_state_e;

   typedef enum logic [1:0] {
      SEENG_JOB_WORD  = 2'h0,
      SEENG_JOB_CLEAR = 2'h1,
      SEENG_JOB_FILL  = 2'h2,
      SEENG_JOB_WIPE  = 2'h3
   } seeng_job_e;

   // Synchronised pin levels
   typedef struct packed {
      logic cs;
      logic sclk;
      logic sin;
      logic pe;
   } seeng_pins_s;

endpackage : seeng_pkg

// ==== rtl/seeng_sync.sv ====
// Three-stage synchroniser with agreement filter for the pin inputs.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps

module seeng_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Raw and filtered levels
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] level
);

   // =========================================================
   // Stages
   // =========================================================
   logic [W-1:0] s1;   // metastable stage, read by s2 only
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Shift chain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Accept a change once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               level[i] <= s3[i];
            end
         end
      end
   end

endmodule : seeng_sync

// ==== verif/seeng_engine_props.sv ====
// Checker for the engine pins: status, output timing and busy span.
// Assumes it is bound to seeng_engine and sees only its ports.
`timescale 1ns/1ps

module seeng_engine_props #(
   parameter int PROG_CYCLES = 2000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Host pins
   input wire logic chip_select,
   input wire logic serial_clock_in,
   // Device answer
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic busy
);
   // =====================================================
   // Helper logic
   // =====================================================
   int         busy_cnt;  // Length of the current busy run
   logic [3:0] age;       // Cycles since clock or select rose
   logic       sk_q;      // Serial clock, one cycle back
   logic       cs_q;      // Select, one cycle back

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Busy run counter, cleared when busy drops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy ? busy_cnt + 1 : 0;
      end
   end

   // Age saturates so that it never wraps back into range
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sk_q <= 1'b0;
         cs_q <= 1'b0;
         age  <= 4'hF;
      end else begin
         sk_q <= serial_clock_in;
         cs_q <= chip_select;
         if ((serial_clock_in && !sk_q) || (chip_select && !cs_q)) begin
            age <= 4'h0;
         end else if (age != 4'hF) begin
            age <= age + 4'h1;
         end
      end
   end

   a_oe_released: assert property (
      (!chip_select) [*8] |-> serial_out_oe_n)
      else $error("output driven while deselected");
   a_busy_launch: assert property (
      $rose(busy) |-> !chip_select)
      else $error("cycle started while selected");
   a_launch_no_clock: assert property (
      $rose(busy) |-> !serial_clock_in)
      else $error("cycle started with serial clock high");
   a_busy_bounded: assert property (
      busy |-> busy_cnt <= PROG_CYCLES + 8)
      else $error("self-timed cycle too long");
   a_busy_full: assert property (
      $fell(busy) |-> busy_cnt >= PROG_CYCLES - 8)
      else $error("self-timed cycle too short");
   a_status_busy: assert property (
      (busy && chip_select) [*8] |-> !serial_out_oe_n && !serial_out)
      else $error("busy status not low");
   a_status_ready: assert property (
      $fell(busy) ##1 chip_select [*8] |-> !serial_out_oe_n && serial_out)
      else $error("ready status not high");
   a_out_on_rise: assert property (
      $changed(serial_out) && !serial_out_oe_n && !$past(serial_out_oe_n)
      && !busy && !$past(busy, 8) |-> age <= 4'h9)
      else $error("output changed away from a clock rise");
endmodule : seeng_engine_props

bind seeng_engine seeng_engine_props #(.PROG_CYCLES(PROG_CYCLES))
   i_seeng_engine_props (.clk(clk), .arst_n(arst_n),
   .chip_select(chip_select), .serial_clock_in(serial_clock_in),
   .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
   .busy(busy));

// ==== verif/seeng_host.sv ====
// Host model: drives select, serial clock and data, polls status.
// Assumes clk is the bench clock; pins move on its falling edge.
`timescale 1ns/1ps

module seeng_host (
   // Clock and device answer
   input  wire logic clk,
   input  wire logic serial_out,
   input  wire logic serial_out_oe_n,
   // Pins towards the device
   output logic      chip_select,
   output logic      serial_clock_in,
   output logic      serial_in,
   output logic      program_enable_pin
);
   // =====================================================
   // Line level and bit tasks
   // =====================================================
   logic do_line;  // Released line shows the inverse
   assign do_line = serial_out_oe_n ? ~serial_out : serial_out;

   // Idle pins from time zero
   initial begin
      chip_select        = 1'b0;
      serial_clock_in    = 1'b0;
      serial_in          = 1'b0;
      program_enable_pin = 1'b1;
   end

   // Wait n falling clock edges
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   // Select, then give the synchroniser time
   task automatic sel();
      chip_select = 1'b1;
      tick(10);
   endtask : sel

   // Deselect for the minimum deselect time
   task automatic desel();
      chip_select = 1'b0;
      tick(10);
   endtask : desel

   // Data set while low, taken on the rise; q read late in high phase
   task automatic io(input logic b, output logic q);
      serial_in = b;
      tick(10);
      serial_clock_in = 1'b1;
      tick(10);
      q = do_line;
      serial_clock_in = 1'b0;
   endtask : io

   // Start bit, opcode and address, MSB first
   task automatic cmd(input logic [1:0] op, input logic [9:0] a,
                      output logic q);
      logic [12:0] v;
      v = {1'b1, op, a};
      for (int i = 12; i >= 0; i--) begin
         io(v[i], q);
      end
   endtask : cmd

   // Sixteen bits out and sixteen answered bits back
   task automatic word(input logic [15:0] d, output logic [15:0] q);
      for (int i = 15; i >= 0; i--) begin
         io(d[i], q[i]);
      end
   endtask : word

   // Reselect and wait for ready, bounded by lim cycles
   task automatic poll(input int lim, output logic ok);
      ok = 1'b0;
      sel();
      for (int i = 0; i < lim && !ok; i++) begin
         ok = (do_line === 1'b1);
         tick(1);
      end
      tick(10);
      desel();
   endtask : poll
endmodule : seeng_host

// ==== verif/seeng_engine_tb.sv ====
// Bench for the engine: the host model drives every serial pin.
// Assumes a 100 MHz clock and a shortened self-timed cycle.
`timescale 1ns/1ps

module seeng_engine_tb;
   // =====================================================
   // Signals, instances and checks
   // =====================================================
   localparam int PROG = 2000;  // Short cycle, still above 1024
   logic        clk, arst_n, chip_select, serial_clock_in, serial_in;
   logic        program_enable_pin, serial_out, serial_out_oe_n, busy;
   logic        q;            // Bit after the last command edge
   logic [15:0] w;            // Answered word
   int          miscompares;  // Mismatches
   int          compares;     // Comparisons made

   seeng_engine #(.PROG_CYCLES(PROG)) i_seeng_engine (.clk(clk),
      .arst_n(arst_n), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_in(serial_in),
      .program_enable_pin(program_enable_pin), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .busy(busy));
   seeng_host i_seeng_host (.clk(clk), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_in(serial_in),
      .program_enable_pin(program_enable_pin));

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h, want %h", $time, seen, exp);
      end
   endtask : check

   // Counts, verdict, end of run
   task automatic tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Modifying command; go says whether a cycle must start
   task automatic modify(input logic [1:0] op, input logic [9:0] a,
                         input logic [15:0] d, input logic go);
      logic ok;
      i_seeng_host.sel();
      i_seeng_host.cmd(op, a, q);
      if (op == seeng_pkg::OP_WRITE || (op == seeng_pkg::OP_SPECIAL
          && a[9:8] == seeng_pkg::SUB_WRITE_ALL)) begin
         i_seeng_host.word(d, w);
      end
      i_seeng_host.desel();
      check(16'(busy), 16'(go));
      if (go) begin
         i_seeng_host.poll(3 * PROG, ok);
         check(16'(ok), 16'h0001);
         if (!ok) begin
            tally_and_finish();
         end
      end
   endtask : modify

   // Special group command with sub-selector s
   task automatic sp(input logic [1:0] s, input logic [15:0] d,
                     input logic go);
      modify(seeng_pkg::OP_SPECIAL, {s, 8'h00}, d, go);
   endtask : sp

   // Two-word sequential read after z ignored zero bits
   task automatic rd2(input logic [9:0] a, input logic [15:0] e0,
                      input logic [15:0] e1, input int z);
      i_seeng_host.sel();
      repeat (z) i_seeng_host.io(1'b0, q);
      i_seeng_host.cmd(seeng_pkg::OP_READ, a, q);
      check(16'(q), 16'h0000);
      i_seeng_host.word(16'h0000, w);
      check(w, e0);
      i_seeng_host.word(16'h0000, w);
      check(w, e1);
      i_seeng_host.desel();
   endtask : rd2

   // Write refused before any enable
   task automatic t_locked();
      modify(seeng_pkg::OP_WRITE, 10'h005, 16'h1234, 1'b0);
   endtask : t_locked

   // Enable, then clear the whole array
   task automatic t_erase_all();
      sp(seeng_pkg::SUB_WRITE_ENABLE, 16'h0000, 1'b0);
      sp(seeng_pkg::SUB_ERASE_ALL, 16'h0000, 1'b1);
      rd2(10'h000, 16'hFFFF, 16'hFFFF, 0);
   endtask : t_erase_all

   // Overwrite without erase, then read across the top address
   task automatic t_write();
      modify(seeng_pkg::OP_WRITE, 10'h005, 16'h1234, 1'b1);
      modify(seeng_pkg::OP_WRITE, 10'h005, 16'h4321, 1'b1);
      modify(seeng_pkg::OP_WRITE, 10'h006, 16'h5A5A, 1'b1);
      modify(seeng_pkg::OP_WRITE, 10'h3FF, 16'hC0DE, 1'b1);
      rd2(10'h005, 16'h4321, 16'h5A5A, 0);
      rd2(10'h3FF, 16'hC0DE, 16'hFFFF, 0);
   endtask : t_write

   // Program enable pin and latch guards
   task automatic t_guard();
      i_seeng_host.program_enable_pin = 1'b0;
      modify(seeng_pkg::OP_WRITE, 10'h005, 16'h0000, 1'b0);
      sp(seeng_pkg::SUB_WRITE_DISABLE, 16'h0000, 1'b0);
      i_seeng_host.program_enable_pin = 1'b1;
      modify(seeng_pkg::OP_WRITE, 10'h005, 16'h0000, 1'b0);
      modify(seeng_pkg::OP_ERASE, 10'h006, 16'h0000, 1'b0);
      rd2(10'h005, 16'h4321, 16'h5A5A, 0);
      i_seeng_host.program_enable_pin = 1'b0;
      sp(seeng_pkg::SUB_WRITE_ENABLE, 16'h0000, 1'b0);
      i_seeng_host.program_enable_pin = 1'b1;
   endtask : t_guard

   // Single erase, then stray zeros before the next start bit
   task automatic t_erase();
      modify(seeng_pkg::OP_ERASE, 10'h006, 16'h0000, 1'b1);
      rd2(10'h005, 16'h4321, 16'hFFFF, 2);
   endtask : t_erase

   // Fill every word over mixed contents
   task automatic t_fill();
      sp(seeng_pkg::SUB_WRITE_ALL, 16'h0F0F, 1'b1);
      rd2(10'h3FF, 16'h0F0F, 16'h0F0F, 0);
   endtask : t_fill

   // Reset, then every scenario in turn
   initial begin
      miscompares = 0;
      compares    = 0;
      arst_n      = 1'b0;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      check(16'(serial_out_oe_n), 16'h0001);
      t_locked();
      t_erase_all();
      t_write();
      t_guard();
      t_erase();
      t_fill();
      tally_and_finish();
   end
endmodule : seeng_engine_tb
